/* design/sfp_power_reset_ctrl.sv */
/*
  Power-state and cold-reset sequencer of a serial flash.
  Assumes chip select, the lane-3 pin, the quad-enable bit and the busy flag
  are synchronous to ref_clk_i; resetn_i stands for the supply crossing its
  minimum operating level.
*/
// Summary of operation
// - Chip select low after initialisation means active power mode
// - Deselected stays active until pending work ends
// - Initialisation runs until power-up delay elapses
// - Lane-3 is reset when deselected long or quad off
// - Reset input ignored during initialisation
// - Power-up delay at most 300 microseconds
// - Initialisation ends in standby, write latch cleared
module sfp_power_reset_ctrl
  import sfp_pkg::*;
#(
  parameter int unsigned POWER_UP_CNT = sfp_pkg::POWER_UP_CYCLES,
  parameter int unsigned HOLD_CNT     = sfp_pkg::HOLD_CYCLES,
  parameter int unsigned SETUP_CNT    = sfp_pkg::SETUP_CYCLES,
  parameter int unsigned PULSE_CNT    = sfp_pkg::PULSE_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic chip_select_n_i,
  input  wire logic quad_lane3_pin_i,
  input  wire logic quad_enable_volatile_i,
  input  wire logic work_pending_i,
  output logic      init_busy_o,
  output logic      active_mode_o,
  output logic      standby_mode_o,
  output logic      lane3_is_reset_o,
  output logic      restart_req_o,
  output logic      write_enable_latch_clr_o,
  output logic      cmd_accept_o
);
  import sfp_pkg::*;

  // Counts that the counters cannot hold are refused at elaboration, and so is a
  // power-up count longer than the longest power-up delay allowed.
  if (POWER_UP_CNT < 1 || POWER_UP_CNT > POWER_UP_CYCLES || HOLD_CNT < 1 ||
      SETUP_CNT < 1 || PULSE_CNT < 1 || PULSE_CNT >= (1 << CNT_W) ||
      SETUP_CNT >= (1 << CNT_W) || HOLD_CNT >= (1 << CNT_W)) begin : g_bad_count
    $error("sfp_power_reset_ctrl: count parameter out of range");
  end

  // ---------------------------------------------------------------------------
  // Power state and initialisation timer
  // ---------------------------------------------------------------------------
  sfp_state_e       state_q, state_d;
  logic [CNT_W-1:0] por_cnt_q, por_cnt_d;
  logic             wel_clr_q, wel_clr_d;

  always_comb begin
    state_d   = state_q;
    por_cnt_d = por_cnt_q;
    wel_clr_d = 1'b0;
    case (state_q)
      SFP_ST_POR: begin
        // Lane-3 and chip select are not looked at here at all.
        if (por_cnt_q == CNT_W'(POWER_UP_CNT - 1)) begin
          state_d   = SFP_ST_STANDBY;
          wel_clr_d = 1'b1;
        end else begin
          por_cnt_d = por_cnt_q + 1'b1;
        end
      end
      SFP_ST_STANDBY: begin
        if (!chip_select_n_i) begin
          state_d = SFP_ST_ACTIVE;
        end
      end
      SFP_ST_ACTIVE: begin
        if (chip_select_n_i && !work_pending_i) begin
          state_d = SFP_ST_STANDBY;
        end
      end
      default: state_d = SFP_ST_POR;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= SFP_ST_POR;
      por_cnt_q <= '0;
      wel_clr_q <= RST_WEL;
    end else begin
      state_q   <= state_d;
      por_cnt_q <= por_cnt_d;
      wel_clr_q <= wel_clr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Lane-3 reset function
  // ---------------------------------------------------------------------------
  // Deselect time and the high time of the pin are counted, saturating; the low time counts only up to the pulse width.
  logic [CNT_W-1:0] desel_cnt_q, desel_cnt_d;
  logic [CNT_W-1:0] high_cnt_q, high_cnt_d;
  logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
  logic             armed_q, armed_d;
  logic             lane3_rst_q, lane3_rst_d;
  logic             req_q, req_d;
  logic             init_q, act_q, stby_q, acc_q;
  logic             in_por;

  assign in_por = (state_q == SFP_ST_POR);

  always_comb begin
    desel_cnt_d = desel_cnt_q;
    high_cnt_d  = high_cnt_q;
    low_cnt_d   = low_cnt_q;
    armed_d     = armed_q;
    req_d       = 1'b0;
    if (!chip_select_n_i) begin
      desel_cnt_d = '0;
    end else if (desel_cnt_q != '1) begin
      desel_cnt_d = desel_cnt_q + 1'b1;
    end
    lane3_rst_d = !quad_enable_volatile_i ||
                  (chip_select_n_i && desel_cnt_q >= CNT_W'(PULSE_CNT));
    if (in_por) begin
      high_cnt_d = '0;
      low_cnt_d  = '0;
      armed_d    = 1'b0;
    end else if (quad_lane3_pin_i) begin
      low_cnt_d = '0;
      if (high_cnt_q != '1) begin
        high_cnt_d = high_cnt_q + 1'b1;
      end
      // A restart needs the pin high for the setup time first.
      if (high_cnt_q >= CNT_W'(SETUP_CNT - 1)) begin
        armed_d = 1'b1;
      end
    end else begin
      high_cnt_d = '0;
      if (lane3_rst_q && armed_q) begin
        if (low_cnt_q == CNT_W'(PULSE_CNT - 1)) begin
          req_d   = 1'b1;
          armed_d = 1'b0;
        end else begin
          low_cnt_d = low_cnt_q + 1'b1;
        end
      end else begin
        low_cnt_d = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      desel_cnt_q <= '0;
      high_cnt_q  <= '0;
      low_cnt_q   <= '0;
      armed_q     <= 1'b0;
      lane3_rst_q <= 1'b0;
      req_q       <= 1'b0;
      init_q      <= 1'b1;
      act_q       <= RST_ACTIVE_MODE;
      stby_q      <= 1'b0;
      acc_q       <= 1'b0;
    end else begin
      desel_cnt_q <= desel_cnt_d;
      high_cnt_q  <= high_cnt_d;
      low_cnt_q   <= low_cnt_d;
      armed_q     <= armed_d;
      lane3_rst_q <= lane3_rst_d;
      req_q       <= req_d;
      init_q      <= (state_d == SFP_ST_POR);
      act_q       <= (state_d == SFP_ST_ACTIVE);
      stby_q      <= (state_d == SFP_ST_STANDBY);
      // Commands are refused until the power-up delay has passed.
      acc_q       <= (state_d != SFP_ST_POR);
    end
  end

  assign init_busy_o              = init_q;
  assign active_mode_o            = act_q;
  assign standby_mode_o           = stby_q;
  assign lane3_is_reset_o         = lane3_rst_q;
  assign restart_req_o            = req_q;
  assign write_enable_latch_clr_o = wel_clr_q;
  assign cmd_accept_o             = acc_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_select_active;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (!init_q && !chip_select_n_i) |=> active_mode_o;
  endproperty
  a_select_active: assert property (p_select_active)
    else $error("Not active while selected.");

  property p_stay_active;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (active_mode_o && work_pending_i) |=> active_mode_o;
  endproperty
  a_stay_active: assert property (p_stay_active)
    else $error("Left active mode with work pending.");

  property p_to_standby;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (active_mode_o && chip_select_n_i && !work_pending_i) |=> standby_mode_o;
  endproperty
  a_to_standby: assert property (p_to_standby)
    else $error("No standby after work ended.");

  property p_init_len;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (init_busy_o && por_cnt_q < CNT_W'(POWER_UP_CNT - 1)) |=> init_busy_o;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("Initialisation ended early.");

  property p_init_end;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      $fell(init_busy_o) |-> standby_mode_o && write_enable_latch_clr_o && cmd_accept_o;
  endproperty
  a_init_end: assert property (p_init_end)
    else $error("Initialisation did not end in standby with latch clear.");

  property p_no_restart_in_por;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      init_busy_o |-> !restart_req_o;
  endproperty
  a_no_restart_in_por: assert property (p_no_restart_in_por)
    else $error("Restart during initialisation.");

  property p_lane3_quad_off;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !quad_enable_volatile_i |=> lane3_is_reset_o;
  endproperty
  a_lane3_quad_off: assert property (p_lane3_quad_off)
    else $error("Lane 3 not reset with quad mode off.");

  property p_lane3_selected;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (!chip_select_n_i && quad_enable_volatile_i) |=> !lane3_is_reset_o;
  endproperty
  a_lane3_selected: assert property (p_lane3_selected)
    else $error("Lane 3 taken as reset while selected in quad mode.");

  property p_restart_after_low;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      restart_req_o |-> $past(!quad_lane3_pin_i) && !init_busy_o;
  endproperty
  a_restart_after_low: assert property (p_restart_after_low)
    else $error("Restart without low lane 3.");

  c_init_done: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(init_busy_o));
  c_active: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(active_mode_o));
  c_busy_hold: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    active_mode_o && chip_select_n_i && work_pending_i);
  c_restart: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    restart_req_o);

endmodule

/* pkg/sfp_pkg.sv */
/*
  Package for the flash power and cold-reset sequencer: timing figures,
  derived cycle counts and the sequencer state type.
  Assumes a 100 MHz time base on ref_clk_i.
*/
package sfp_pkg;

  // ---------------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ---------------------------------------------------------------------------
  // Timing figures in their own units and derived cycle counts
  // ---------------------------------------------------------------------------
  localparam int unsigned POWER_UP_DELAY_US       = 300;
  localparam int unsigned RESTART_HOLD_TIME_NS    = 50;
  localparam int unsigned RESTART_SETUP_TIME_NS   = 50;
  localparam int unsigned RESTART_PULSE_WIDTH_NS  = 200;

  // The longest power-up time rounds down; least times round up.
  localparam int unsigned POWER_UP_CYCLES = (POWER_UP_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYCLES     =
    (RESTART_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYCLES    =
    (RESTART_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYCLES    =
    (RESTART_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 16;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic RST_ACTIVE_MODE = 1'b0;
  localparam logic RST_WEL         = 1'b0;

  typedef enum logic [1:0] {
    SFP_ST_POR,
    SFP_ST_STANDBY,
    SFP_ST_ACTIVE
  } sfp_state_e;

endpackage

/* verification/sfp_host_model.sv */
/*
  Host-side model of the serial-bus controller: drives chip select and the
  lane-3 pin. Assumes ref_clk_i is the device time base and that callers
  enter its tasks just after a rising edge.
*/
module sfp_host_model #(
  parameter int unsigned HOLD_CNT  = sfp_pkg::HOLD_CYCLES,
  parameter int unsigned SETUP_CNT = sfp_pkg::SETUP_CYCLES
) (
  input  wire logic ref_clk_i,
  output logic      chip_select_n_o,
  output logic      lane3_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------------------
  // Select stays high with the supply; the pin rests at its pull-up level.
  initial begin
    chip_select_n_o = 1'b1;
    lane3_o         = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Requests
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Selecting always waits out the hold gap, whether or not a restart was near.
  task automatic sel(input logic v);
    if (!v)
      step(HOLD_CNT + 1);
    chip_select_n_o = v;
  endtask

  task automatic pin(input logic v, input int n);
    if (!v)
      step(SETUP_CNT + 1);
    lane3_o = v;
    step(n);
  endtask
endmodule

/* verification/sfp_power_reset_ctrl_tb_top.sv */
/*
  Self-checking bench of the power and cold-reset sequencer.
  Assumes the host model drives select and lane 3; short power-up count in sim.
*/
module sfp_power_reset_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned PU = 20;
  localparam int unsigned PC = sfp_pkg::PULSE_CYCLES;

  logic ref_clk_i;
  logic resetn_i;
  logic cs_n;
  logic lane3;
  logic quad_en;
  logic pending;
  logic init_busy;
  logic active;
  logic standby;
  logic l3_rst;
  logic restart;
  logic wel_clr;
  logic accept;
  int   mismatches;
  int   n_checks;
  int   n_restart;

  sfp_power_reset_ctrl #(.POWER_UP_CNT(PU)) u_sfp_power_reset_ctrl (
    .ref_clk_i               (ref_clk_i),
    .resetn_i                (resetn_i),
    .chip_select_n_i         (cs_n),
    .quad_lane3_pin_i        (lane3),
    .quad_enable_volatile_i  (quad_en),
    .work_pending_i          (pending),
    .init_busy_o             (init_busy),
    .active_mode_o           (active),
    .standby_mode_o          (standby),
    .lane3_is_reset_o        (l3_rst),
    .restart_req_o           (restart),
    .write_enable_latch_clr_o(wel_clr),
    .cmd_accept_o            (accept)
  );

  sfp_host_model u_sfp_host_model (
    .ref_clk_i      (ref_clk_i),
    .chip_select_n_o(cs_n),
    .lane3_o        (lane3)
  );

  // ---------------------------------------------------------------------------
  // Clock, restart counter and shared tasks
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (restart === 1'b1)
      n_restart++;
  end

  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Lane 3 is driven low partway through initialisation and held low past its end.
  task automatic t_init();
    tick(4);
    check(init_busy, 1'b1);
    check(standby, 1'b0);
    resetn_i = 1'b1;
    fork
      u_sfp_host_model.pin(1'b0, PU);
      begin
        tick(PU - 1);
        check(init_busy, 1'b1);
        check(accept, 1'b0);
        tick(1);
        check(init_busy, 1'b0);
        check(standby, 1'b1);
        check(accept, 1'b1);
        check(wel_clr, 1'b1);
        tick(1);
        check(wel_clr, 1'b0);
      end
    join
    u_sfp_host_model.pin(1'b1, 2);
    check(n_restart == 0, 1'b1);
  endtask

  task automatic t_modes();
    u_sfp_host_model.sel(1'b0);
    tick(1);
    check(active, 1'b1);
    check(standby, 1'b0);
    pending = 1'b1;
    u_sfp_host_model.sel(1'b1);
    tick(3);
    check(active, 1'b1);
    check(standby, 1'b0);
    pending = 1'b0;
    tick(1);
    check(active, 1'b0);
    check(standby, 1'b1);
  endtask

  task automatic t_lane3();
    quad_en = 1'b1;
    u_sfp_host_model.sel(1'b0);
    tick(2);
    check(l3_rst, 1'b0);
    u_sfp_host_model.sel(1'b1);
    tick(PC - 2);
    check(l3_rst, 1'b0);
    tick(4);
    check(l3_rst, 1'b1);
    u_sfp_host_model.sel(1'b0);
    tick(2);
    check(l3_rst, 1'b0);
    quad_en = 1'b0;
    tick(2);
    check(l3_rst, 1'b1);
    u_sfp_host_model.sel(1'b1);
  endtask

  // One cycle short, then long enough, then masked by quad mode under select.
  task automatic t_restart();
    u_sfp_host_model.pin(1'b0, PC - 1);
    u_sfp_host_model.pin(1'b1, 2);
    check(n_restart == 0, 1'b1);
    u_sfp_host_model.pin(1'b0, PC + 3);
    u_sfp_host_model.pin(1'b1, 2);
    check(n_restart == 1, 1'b1);
    quad_en = 1'b1;
    u_sfp_host_model.sel(1'b0);
    u_sfp_host_model.pin(1'b0, PC + 3);
    u_sfp_host_model.pin(1'b1, 2);
    check(n_restart == 1, 1'b1);
    u_sfp_host_model.sel(1'b1);
  endtask

  // Supply dip while active: all state returns to power-on, then a full restart.
  task automatic t_reinit();
    u_sfp_host_model.sel(1'b0);
    tick(1);
    check(active, 1'b1);
    resetn_i = 1'b0;
    u_sfp_host_model.sel(1'b1);
    tick(2);
    check(init_busy, 1'b1);
    check(active, 1'b0);
    check(standby, 1'b0);
    check(accept, 1'b0);
    check(l3_rst, 1'b0);
    check(restart, 1'b0);
    check(wel_clr, 1'b0);
    resetn_i = 1'b1;
    tick(PU - 1);
    check(init_busy, 1'b1);
    tick(1);
    check(init_busy, 1'b0);
    check(standby, 1'b1);
    check(accept, 1'b1);
    check(wel_clr, 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    resetn_i   = 1'b0;
    quad_en    = 1'b0;
    pending    = 1'b0;
    mismatches = 0;
    n_checks   = 0;
    n_restart  = 0;
    t_init();
    t_modes();
    t_lane3();
    t_restart();
    t_reinit();
    end_sim();
  end

  initial begin
    #50us;
    mismatches++;
    end_sim();
  end
endmodule
